// ### dv/bsab_host_model.sv
/*
 * Host-side partner: drives address, burst and write pins as a bus
 * master would, one cycle per task call, from the caller's process.
 * Assumes the caller runs on pclk and owns the order pin itself.
 */
`timescale 1ns/1ns
module bsab_host_model (
    // clock
    input  wire logic                        pclk,
    // address and burst control
    output logic      [bsab_pkg::ADDR_W-1:0] addr,
    output logic                             burst_start,
    output logic                             burst_advance_n,
    // write controls
    output logic                             global_write_n,
    output logic                             lane_write_enable_n,
    output logic                             lane_a_select_n,
    output logic                             lane_b_select_n
);
    initial begin
        addr = '0;
        burst_start = 1'b0;
        burst_advance_n = 1'b1;
        {global_write_n, lane_write_enable_n} = 2'h3;
        {lane_a_select_n, lane_b_select_n} = 2'h3;
    end
    // one random bus cycle; low address lines are the bus lsbs
    task automatic drive(input logic [31:0] r);
        @(posedge pclk);
        addr <= r[bsab_pkg::ADDR_W-1:0];
        burst_start <= (r[20:18] == 3'h0);
        burst_advance_n <= r[21];
        global_write_n <= r[22] | r[23];
        lane_write_enable_n <= r[24];
        lane_a_select_n <= r[25];
        lane_b_select_n <= r[26];
    endtask
    // quiet cycle: no burst activity, write controls held at w
    task automatic hold(input logic [3:0] w);
        @(posedge pclk);
        addr <= ~addr; // address lines never sit at a stale value
        burst_start <= 1'b0;
        burst_advance_n <= 1'b1;
        {global_write_n, lane_write_enable_n} <= w[3:2];
        {lane_a_select_n, lane_b_select_n} <= w[1:0];
    endtask
endmodule

// ### dv/tb_top.sv
/*
 * Self-checking bench: random host traffic against a cycle model,
 * plus register reads over APB, run once per burst order.
 * Assumes the design answers APB with pready and samples pins at pclk.
 */
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("unexpected at %0t: %s", $time, msg); \
        end \
    end
module tb_top;
    logic                          pclk;
    logic                          presetn;
    logic                          psel, penable, pwrite;
    logic [bsab_pkg::PADDR_W-1:0]  paddr;
    logic [31:0]                   pwdata, prdata;
    logic                          pready, pslverr;
    logic [bsab_pkg::ADDR_W-1:0]   h_addr, mem_addr, e_addr;
    logic                          h_start, h_adv_n, order_sel;
    logic                          h_gw_n, h_we_n, h_a_n, h_b_n;
    logic                          lane_write_a, lane_write_b;
    logic [1:0]                    e_base, e_cnt, e_type;
    logic [31:0]                   e_wr;
    logic                          n_wa, n_wb, clr;
    int                            checked, bad_count;

    bsab_burst_sram_ctrl i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addr(h_addr), .burst_start(h_start),
        .burst_advance_n(h_adv_n), .burst_order_select(order_sel),
        .global_write_n(h_gw_n), .lane_write_enable_n(h_we_n),
        .lane_a_select_n(h_a_n), .lane_b_select_n(h_b_n),
        .mem_addr(mem_addr), .lane_write_a(lane_write_a),
        .lane_write_b(lane_write_b));
    bsab_host_model i_host (.pclk(pclk), .addr(h_addr),
        .burst_start(h_start), .burst_advance_n(h_adv_n),
        .global_write_n(h_gw_n), .lane_write_enable_n(h_we_n),
        .lane_a_select_n(h_a_n), .lane_b_select_n(h_b_n));

    always #5 pclk = ~pclk;

    // reference model: type code is {lane b, lane a}
    assign n_wa = !h_gw_n | (!h_we_n & !h_a_n);
    assign n_wb = !h_gw_n | (!h_we_n & !h_b_n);
    assign clr = psel & penable & pwrite & pwdata[0]
               & (paddr == bsab_pkg::REG_CTRL);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e_addr <= '0;
            e_base <= 2'h0;
            e_cnt <= 2'h0;
            e_type <= 2'h0;
            e_wr <= 32'h0;
        end else begin
            if (h_start) begin
                e_addr <= h_addr;
                e_base <= h_addr[1:0];
                e_cnt <= 2'h0;
            end else if (!h_adv_n) begin
                e_cnt <= e_cnt + 2'h1;
                e_addr[1:0] <= order_sel ? e_base ^ (e_cnt + 2'h1)
                                         : e_base + e_cnt + 2'h1;
            end
            e_type <= {n_wb, n_wa};
            // counter follows the registered strobes, one edge late
            e_wr <= clr ? 32'(|e_type) : e_wr + 32'(|e_type);
        end
    end

    // outputs settle well before the falling edge
    always @(negedge pclk) begin
        if (presetn === 1'b1) begin
            `CHK(mem_addr, e_addr, "burst address")
            `CHK(lane_write_a, e_type[0], "lane a strobe")
            `CHK(lane_write_b, e_type[1], "lane b strobe")
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] exp_d, input logic exp_e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= exp_d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait ends once pready is seen high; the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        `CHK(pready, 1'b1, "no pready")
        `CHK(pslverr, exp_e, "pslverr")
        if (!wr) begin
            `CHK(prdata, exp_d, "read data")
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_phase(input logic order);
        logic [3:0]  pat [5];
        logic [31:0] st;
        int          i;
        pat = '{4'h7, 4'h9, 4'hA, 4'h8, 4'hB};
        @(posedge pclk);
        presetn <= 1'b0;
        order_sel <= order;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 400; i++) begin
            i_host.drive($urandom);
        end
        // global write, lane a, lane b, both lanes, enable with no lane
        for (i = 0; i < 5; i++) begin
            repeat (3) i_host.hold(pat[i]);
            #1;
            st = {25'h0, order, e_type, e_cnt, e_addr[1:0]};
            apb(1'b0, bsab_pkg::REG_STATUS, st, 1'b0);
        end
        apb(1'b0, bsab_pkg::REG_WRCNT, e_wr, 1'b0);
        apb(1'b1, bsab_pkg::REG_STATUS, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, bsab_pkg::REG_STATUS, st, 1'b0);
        // clear while writes run: the write of that cycle still counts
        i_host.hold(4'h3);
        apb(1'b1, bsab_pkg::REG_CTRL, 32'h0000_0001, 1'b0);
        repeat (2) i_host.hold(4'hB);
        #1;
        apb(1'b0, bsab_pkg::REG_WRCNT, e_wr, 1'b0);
        apb(1'b1, bsab_pkg::REG_CTRL, 32'h0000_0001, 1'b0);
        apb(1'b0, bsab_pkg::REG_WRCNT, 32'h0, 1'b0);
        apb(1'b0, bsab_pkg::REG_CTRL, 32'h0, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 1'b1);
        $display("test with order %0d done", order);
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = '0;
        pwdata = 32'h0;
        order_sel = 1'b0;
        checked = 0;
        bad_count = 0;
        void'($urandom(32'h02D1));
        run_phase(1'b0);
        // second pass re-enters reset mid-run with the other order
        run_phase(1'b1);
        report_and_stop();
    end

    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end
endmodule

// ### verilog/bsab_burst_seq.sv
/*
 * Two-bit burst address sequencer: loads a start address and steps the
 * low bits through four beats in linear or interleaved order.
 * Assumes pins synchronous to pclk; the order pin is static.
 */
`timescale 1ns/1ns
module bsab_burst_seq (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // bus side
    input  wire logic                        burst_start,
    input  wire logic                        burst_advance_n,
    input  wire logic                        burst_order_select,
    input  wire logic [bsab_pkg::ADDR_W-1:0] addr,
    // sequenced address
    output logic      [bsab_pkg::ADDR_W-1:0] burst_addr,
    output logic      [bsab_pkg::LOW_W-1:0]  beat_count
);

    logic [bsab_pkg::UPPER_W-1:0] upper_q, upper_d;
    logic [bsab_pkg::LOW_W-1:0]   base_q, base_d;
    logic [bsab_pkg::LOW_W-1:0]   cnt_q, cnt_d;
    logic [bsab_pkg::LOW_W-1:0]   low_q, low_d;

    always_comb begin
        upper_d = upper_q;
        base_d  = base_q;
        cnt_d   = cnt_q;
        low_d   = low_q;
        if (burst_start) begin
            // first beat straight from the bus
            upper_d = addr[bsab_pkg::ADDR_W-1:bsab_pkg::LOW_W];
            base_d  = addr[bsab_pkg::LOW_W-1:0];
            cnt_d   = bsab_pkg::LOW_RST;
        end else if (!burst_advance_n) begin
            // 2-bit count wraps after the fourth beat
            cnt_d = bsab_pkg::LOW_W'(cnt_q + bsab_pkg::CNT_STEP);
            // order pin read live, never latched
            low_d = bsab_pkg::bsab_beat_low(base_q, cnt_d,
                                            burst_order_select);
        end
        if (burst_start)
            low_d = base_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_q <= bsab_pkg::UPPER_RST;
            base_q  <= bsab_pkg::LOW_RST;
            cnt_q   <= bsab_pkg::LOW_RST;
            low_q   <= bsab_pkg::LOW_RST;
        end else begin
            upper_q <= upper_d;
            base_q  <= base_d;
            cnt_q   <= cnt_d;
            low_q   <= low_d;
        end
    end

    assign burst_addr = {upper_q, low_q};
    assign beat_count = cnt_q;

    AST_SEQ_MATCHES_BASE: assert property (
        @(posedge pclk) disable iff (!presetn)
        low_q == bsab_pkg::bsab_beat_low(base_q, cnt_q, burst_order_select))
        else $error("low bits do not match base and beat count");

endmodule

// ### verilog/bsab_burst_sram_ctrl.sv
/*
 * Top of the burst SRAM address and byte-write block: sequencer, write
 * decode, a write-cycle counter and an APB register port.
 * Assumes host pins synchronous to pclk and a static order pin.
 */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module bsab_burst_sram_ctrl (
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [bsab_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // host address and burst control
    input  wire logic [bsab_pkg::ADDR_W-1:0]  addr,
    input  wire logic                         burst_start,
    input  wire logic                         burst_advance_n,
    input  wire logic                         burst_order_select,
    // host write controls
    input  wire logic                         global_write_n,
    input  wire logic                         lane_write_enable_n,
    input  wire logic                         lane_a_select_n,
    input  wire logic                         lane_b_select_n,
    // array side
    output logic      [bsab_pkg::ADDR_W-1:0]  mem_addr,
    output logic                              lane_write_a,
    output logic                              lane_write_b
);

    logic [bsab_pkg::LOW_W-1:0] beat_count;
    bsab_pkg::bsab_cycle_t      cycle_type;
    logic [31:0]                wrcnt_q, wrcnt_d;
    logic [31:0]                prdata_q, prdata_d;
    logic                       setup_ph;
    logic                       access_ph;
    logic                       hit;
    logic                       clr_wr;
    logic                       is_write;

    bsab_burst_seq u_seq (
        .pclk               (pclk),
        .presetn            (presetn),
        .burst_start        (burst_start),
        .burst_advance_n    (burst_advance_n),
        .burst_order_select (burst_order_select),
        .addr               (addr),
        .burst_addr         (mem_addr),
        .beat_count         (beat_count)
    );

    bsab_write_decode u_dec (
        .pclk                (pclk),
        .presetn             (presetn),
        .global_write_n      (global_write_n),
        .lane_write_enable_n (lane_write_enable_n),
        .lane_a_select_n     (lane_a_select_n),
        .lane_b_select_n     (lane_b_select_n),
        .lane_write_a        (lane_write_a),
        .lane_write_b        (lane_write_b),
        .cycle_type          (cycle_type)
    );

    function automatic logic bsab_mapped(
        input logic [bsab_pkg::PADDR_W-1:0] a
    );
        return (a == bsab_pkg::REG_CTRL) || (a == bsab_pkg::REG_STATUS) ||
               (a == bsab_pkg::REG_WRCNT);
    endfunction

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign hit       = bsab_mapped(paddr);
    assign clr_wr    = access_ph && pwrite && hit &&
                       (paddr == bsab_pkg::REG_CTRL) &&
                       pwdata[bsab_pkg::CTRL_CLR_BIT];
    assign is_write  = lane_write_a || lane_write_b;

    // zero wait states; unmapped offsets answer with an error
    assign pready  = access_ph;
    assign pslverr = access_ph && !hit;
    assign prdata  = prdata_q;

    always_comb begin
        wrcnt_d  = wrcnt_q;
        prdata_d = prdata_q;
        // a write cycle in the clearing cycle still counts
        if (clr_wr)
            wrcnt_d = is_write ? bsab_pkg::WRCNT_STEP : bsab_pkg::WORD_RST;
        else if (is_write)
            wrcnt_d = wrcnt_q + bsab_pkg::WRCNT_STEP;
        if (setup_ph && !pwrite) begin
            prdata_d = bsab_pkg::WORD_RST;
            case (paddr)
                bsab_pkg::REG_STATUS: begin
                    prdata_d[bsab_pkg::ST_LOW_LSB +: bsab_pkg::LOW_W] =
                        mem_addr[bsab_pkg::LOW_W-1:0];
                    prdata_d[bsab_pkg::ST_CNT_LSB +: bsab_pkg::LOW_W] =
                        beat_count;
                    prdata_d[bsab_pkg::ST_TYPE_LSB +: 2] = cycle_type;
                    prdata_d[bsab_pkg::ST_ORDER_BIT] = burst_order_select;
                end
                bsab_pkg::REG_WRCNT: begin
                    prdata_d = wrcnt_q;
                end
                default: begin
                    prdata_d = bsab_pkg::WORD_RST;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrcnt_q  <= bsab_pkg::WORD_RST;
            prdata_q <= bsab_pkg::WORD_RST;
        end else begin
            wrcnt_q  <= wrcnt_d;
            prdata_q <= prdata_d;
        end
    end

    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hold;
        !burst_start && burst_advance_n;
    endsequence

    sequence s_step;
        !burst_start && !burst_advance_n;
    endsequence

    sequence s_four_steps;
        s_step [*4];
    endsequence

    sequence s_lin_step;
        !burst_start && !burst_advance_n && !burst_order_select;
    endsequence

    sequence s_il_step;
        !burst_start && !burst_advance_n && burst_order_select;
    endsequence

    sequence s_status_rd;
        setup_ph && !pwrite && paddr == bsab_pkg::REG_STATUS;
    endsequence

    AST_LOAD_FIRST: assert property (
        burst_start |=> mem_addr == $past(addr) && beat_count == 2'h0)
        else $error("first beat did not take the bus address");

    AST_LINEAR_STEP: assert property (
        s_step and burst_order_select == bsab_pkg::ORDER_LINEAR
        |=> mem_addr[1:0] == 2'($past(mem_addr[1:0]) + 2'h1))
        else $error("linear beat did not add one");

    AST_INTERLEAVE: assert property (
        burst_start ##1 (s_step and burst_order_select)
        |=> mem_addr[1:0] == ($past(mem_addr[1:0], 1) ^ 2'h1))
        else $error("second interleaved beat wrong");

    AST_UPPER_KEPT: assert property (
        !burst_start |=> mem_addr[17:2] == $past(mem_addr[17:2]))
        else $error("upper address bits moved during burst");

    AST_NO_ADVANCE_HOLDS: assert property (
        s_hold |=> $stable(mem_addr) && $stable(beat_count))
        else $error("address moved without advance");

    AST_WRAP_FOUR: assert property (
        s_four_steps |=> mem_addr == $past(mem_addr, 4))
        else $error("four beats did not return to start");

    AST_LANE_A_ONLY: assert property (
        global_write_n && !lane_write_enable_n && !lane_a_select_n &&
        lane_b_select_n |=> lane_write_a && !lane_write_b)
        else $error("lane a write decode wrong");

    AST_LANE_B_ONLY: assert property (
        global_write_n && !lane_write_enable_n && lane_a_select_n &&
        !lane_b_select_n |=> !lane_write_a && lane_write_b)
        else $error("lane b write decode wrong");

    AST_BOTH_BY_LANES: assert property (
        global_write_n && !lane_write_enable_n && !lane_a_select_n &&
        !lane_b_select_n |=> lane_write_a && lane_write_b)
        else $error("both-lane write decode wrong");

    AST_GLOBAL_WRITE: assert property (
        !global_write_n |=> lane_write_a && lane_write_b &&
        cycle_type == bsab_pkg::BSAB_WR_ALL)
        else $error("global write did not write both lanes");

    AST_READ_CYCLE: assert property (
        global_write_n && (lane_write_enable_n ||
        (lane_a_select_n && lane_b_select_n))
        |=> !lane_write_a && !lane_write_b &&
        cycle_type == bsab_pkg::BSAB_READ)
        else $error("read cycle decoded as write");

    AST_WRCNT_COUNTS: assert property (
        is_write && !clr_wr |=> wrcnt_q == $past(wrcnt_q) + 32'h1)
        else $error("write counter missed a write cycle");

    AST_APB_ANSWER: assert property (
        setup_ph |=> pready || !penable)
        else $error("access phase not answered at once");

    AST_IL_THIRD: assert property (
        burst_start ##1 s_il_step ##1 s_il_step
        |=> mem_addr[1:0] == ($past(mem_addr[1:0], 2) ^ 2'h2))
        else $error("third interleaved beat wrong");

    AST_IL_FOURTH: assert property (
        burst_start ##1 s_il_step [*3]
        |=> mem_addr[1:0] == ($past(mem_addr[1:0], 3) ^ 2'h3))
        else $error("fourth interleaved beat wrong");

    AST_LIN_FOURTH: assert property (
        burst_start ##1 s_lin_step [*3]
        |=> mem_addr[1:0] == 2'($past(mem_addr[1:0], 3) + 2'h3))
        else $error("fourth linear beat wrong");

    AST_STEP_COUNT: assert property (
        s_step |=> beat_count == 2'($past(beat_count) + 2'h1))
        else $error("advance did not step the beat count");

    AST_ENABLE_NO_LANE: assert property (
        global_write_n && !lane_write_enable_n && lane_a_select_n &&
        lane_b_select_n |=> !lane_write_a && !lane_write_b)
        else $error("enable with no lane selected wrote a lane");

    AST_GW_OVERRIDES: assert property (
        !global_write_n && lane_write_enable_n
        |=> lane_write_a && lane_write_b)
        else $error("global write lost without write enable");

    AST_STATUS_ORDER: assert property (
        s_status_rd |=> prdata[bsab_pkg::ST_ORDER_BIT] ==
        $past(burst_order_select))
        else $error("status does not show the order pin");

    AST_STATUS_LOW: assert property (
        s_status_rd |=> prdata[bsab_pkg::ST_LOW_LSB +: bsab_pkg::LOW_W] ==
        $past(mem_addr[bsab_pkg::LOW_W-1:0]))
        else $error("status low address bits wrong");

    AST_STATUS_CNT: assert property (
        s_status_rd |=> prdata[bsab_pkg::ST_CNT_LSB +: bsab_pkg::LOW_W] ==
        $past(beat_count))
        else $error("status beat count wrong");

    AST_STATUS_TYPE: assert property (
        s_status_rd |=> prdata[bsab_pkg::ST_TYPE_LSB +: 2] ==
        $past(cycle_type))
        else $error("status cycle type wrong");

    AST_WRCNT_READ: assert property (
        setup_ph && !pwrite && paddr == bsab_pkg::REG_WRCNT
        |=> prdata == $past(wrcnt_q))
        else $error("write counter read wrong");

    AST_OTHER_READ_ZERO: assert property (
        setup_ph && !pwrite && (paddr == bsab_pkg::REG_CTRL || !hit)
        |=> prdata == bsab_pkg::WORD_RST)
        else $error("control or unmapped read not zero");

    AST_PRDATA_STANDS: assert property (
        !(setup_ph && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");

    AST_CLEAR_SET_WINS: assert property (
        clr_wr && is_write |=> wrcnt_q == bsab_pkg::WRCNT_STEP)
        else $error("write in the clearing cycle was lost");

    AST_CLEAR_IDLE: assert property (
        clr_wr && !is_write |=> wrcnt_q == bsab_pkg::WORD_RST)
        else $error("clear left the write counter nonzero");

    AST_WRCNT_HOLDS: assert property (
        !is_write && !clr_wr |=> $stable(wrcnt_q))
        else $error("write counter moved without a write");

    AST_ERR_ONLY_UNMAPPED: assert property (
        access_ph && hit |-> pready && !pslverr)
        else $error("mapped access answered with an error");

    AST_IDLE_NO_ANSWER: assert property (
        !access_ph |-> !pready && !pslverr)
        else $error("answer outside an access phase");

endmodule

// ### verilog/bsab_pkg.sv
/*
 * Shared constants, types and decode functions for the burst SRAM
 * address sequencer and byte-write decode.
 * Assumes one clock (pclk) and an APB register port of 32-bit words.
 */
package bsab_pkg;

    // address shape
    localparam int ADDR_W  = 18;
    localparam int LOW_W   = 2;
    localparam int UPPER_W = ADDR_W - LOW_W;
    localparam int PADDR_W = 12;

    // burst order pin levels
    localparam logic ORDER_LINEAR      = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    // register byte offsets
    localparam logic [PADDR_W-1:0] REG_CTRL   = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] REG_WRCNT  = 12'h008;

    // field positions
    localparam int CTRL_CLR_BIT   = 0;
    localparam int ST_LOW_LSB     = 0;
    localparam int ST_CNT_LSB     = 2;
    localparam int ST_TYPE_LSB    = 4;
    localparam int ST_ORDER_BIT   = 6;

    // reset values and counter steps
    localparam logic [LOW_W-1:0]   LOW_RST   = 2'h0;
    localparam logic [UPPER_W-1:0] UPPER_RST = 16'h0000;
    localparam logic [31:0]        WORD_RST  = 32'h0000_0000;
    localparam logic [LOW_W-1:0]   CNT_STEP  = 2'h1;
    localparam logic [31:0]        WRCNT_STEP = 32'h0000_0001;

    typedef enum logic [1:0] {
        BSAB_READ,
        BSAB_WR_A,
        BSAB_WR_B,
        BSAB_WR_ALL
    } bsab_cycle_t;

    // low address bits of the beat selected by count
    function automatic logic [LOW_W-1:0] bsab_beat_low(
        input logic [LOW_W-1:0] base,
        input logic [LOW_W-1:0] cnt,
        input logic             order
    );
        if (order == ORDER_INTERLEAVED)
            return base ^ cnt;
        return LOW_W'(base + cnt);
    endfunction

    // cycle type from the sampled write controls
    function automatic bsab_cycle_t bsab_decode(
        input logic gw_n,
        input logic we_n,
        input logic a_n,
        input logic b_n
    );
        if (!gw_n)
            return BSAB_WR_ALL;
        if (we_n)
            return BSAB_READ;
        case ({a_n, b_n})
            2'b00:   return BSAB_WR_ALL;
            2'b01:   return BSAB_WR_A;
            2'b10:   return BSAB_WR_B;
            default: return BSAB_READ;
        endcase
    endfunction

endpackage

// ### verilog/bsab_write_decode.sv
/*
 * Byte-write decode: turns the sampled global write, write enable and
 * two lane selects into per-lane write strobes and a cycle type.
 * Assumes all controls synchronous to pclk, active low.
 */
`timescale 1ns/1ns
module bsab_write_decode (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // write controls
    input  wire logic                  global_write_n,
    input  wire logic                  lane_write_enable_n,
    input  wire logic                  lane_a_select_n,
    input  wire logic                  lane_b_select_n,
    // decoded cycle
    output logic                       lane_write_a,
    output logic                       lane_write_b,
    output bsab_pkg::bsab_cycle_t      cycle_type
);

    bsab_pkg::bsab_cycle_t type_q, type_d;

    always_comb begin
        // global write overrides the lane controls
        type_d = bsab_pkg::bsab_decode(global_write_n, lane_write_enable_n,
                                       lane_a_select_n,
                                       lane_b_select_n);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            type_q <= bsab_pkg::BSAB_READ;
        else
            type_q <= type_d;
    end

    assign cycle_type   = type_q;
    assign lane_write_a = (type_q == bsab_pkg::BSAB_WR_A) ||
                          (type_q == bsab_pkg::BSAB_WR_ALL);
    assign lane_write_b = (type_q == bsab_pkg::BSAB_WR_B) ||
                          (type_q == bsab_pkg::BSAB_WR_ALL);

endmodule
